/* pkg/i2csf_pkg.sv */
// Purpose: constants and state type of the i2c status and flag unit
// Assumes: 32-bit register port, byte addresses
// Notes:   bit positions follow the status and clear register layouts
package i2csf_pkg;

  localparam logic [7:0]  OFS_STATUS  = 8'h18;
  localparam logic [7:0]  OFS_CLEAR   = 8'h1C;
  localparam logic [7:0]  OFS_PEC     = 8'h20;
  localparam logic [7:0]  OFS_RXDATA  = 8'h24;
  localparam logic [7:0]  OFS_TXDATA  = 8'h28;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0001;

  localparam int BIT_ADDR_CODE   = 17;
  localparam int BIT_DIR         = 16;
  localparam int BIT_BUSY        = 15;
  localparam int BIT_ALERT       = 13;
  localparam int BIT_TIMEOUT     = 12;
  localparam int BIT_PEC_ERROR   = 11;
  localparam int BIT_OVERRUN     = 10;
  localparam int BIT_ARB_LOST    = 9;
  localparam int BIT_BUS_ERROR   = 8;
  localparam int BIT_RELOAD_DONE = 7;
  localparam int BIT_XFER_DONE   = 6;
  localparam int BIT_STOP        = 5;
  localparam int BIT_NACK        = 4;
  localparam int BIT_MATCH       = 3;
  localparam int BIT_RX_FULL     = 2;
  localparam int BIT_TX_REQUEST  = 1;
  localparam int BIT_TX_EMPTY    = 0;

  // crc-8 polynomial x^8 + x^2 + x + 1
  localparam logic [7:0] PEC_POLY = 8'h07;

  typedef struct packed {
    logic [6:0] matched_address_code;
    logic       dir;
    logic       busy;
    logic       alert;
    logic       timeout;
    logic       packet_error_flag;
    logic       overrun_underrun_flag;
    logic       arbitration_lost_flag;
    logic       bus_error_flag;
    logic       reload_complete_flag;
    logic       transfer_done_flag;
    logic       stop_seen_flag;
    logic       nack_received_flag;
    logic       match;
    logic       receive_holding_full;
    logic       transmit_request_flag;
    logic       transmit_holding_empty;
    logic       addressed;
    logic [7:0] pec;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic       scl_q;
    logic       sda_q;
    logic       alert_q;
    logic       pec_nack;
    logic       start_clear;
    logic [31:0] rdata;
  } i2csf_state_t;

endpackage

/* logic/i2csf_sync.sv */
// Purpose: two-flop synchroniser for pins entering the clk_i domain
// Assumes: inputs are slow against clk_i
// Notes:   only the second stage leaves the module
`timescale 1ns/1ns
module i2csf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // system clock
  input  wire logic         rstn_i,  // async reset, active low
  input  wire logic [W-1:0] d_i,     // asynchronous inputs
  input  wire logic [W-1:0] init_i,  // unused-level guard, tie high
  output      logic [W-1:0] q_o      // synchronised outputs
);

  logic [W-1:0] meta;
  logic [W-1:0] stage2;

  // idle bus lines are high, so reset to ones avoids a false edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta   <= '1;
      stage2 <= '1;
    end else begin
      meta   <= d_i;
      stage2 <= meta;
    end
  end

  assign q_o = stage2 & init_i;

endmodule

/* logic/i2csf_status_unit.sv */
// Purpose: status flags, flag clear, pec readout and receive data
// Assumes: bus engine events are one-cycle pulses on clk_i
// Notes:   scl, sda and alert pins are sampled through two flops
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module i2csf_status_unit
  import i2csf_pkg::*;
#(
  parameter bit SMBUS_SUPPORT = 1'b1
) (
  input  wire logic       clk_i,                 // system clock
  input  wire logic       rstn_i,                // async reset, low
  input  wire logic [7:0] addr_i,                // register byte address
  input  wire logic [31:0] wdata_i,              // register write data
  input  wire logic       wr_i,                  // write strobe
  input  wire logic       rd_i,                  // read strobe
  output      logic [31:0] rdata_o,              // read data, next cycle
  input  wire logic       peripheral_enable_i,   // block enable
  input  wire logic       smbus_host_mode_i,     // smbus host mode
  input  wire logic       alert_pin_enable_i,    // alert pin enable
  input  wire logic       clock_stretch_disable_i, // no stretching
  input  wire logic       reload_mode_i,         // reload mode
  input  wire logic       automatic_stop_mode_i, // automatic stop
  input  wire logic       slave_byte_control_i,  // slave byte control
  input  wire logic       packet_check_enable_i, // pec enable
  input  wire logic       master_mode_i,         // block is master
  input  wire logic       scl_i,                 // scl pin level
  input  wire logic       sda_i,                 // sda pin level
  input  wire logic       alert_input_pin_i,     // alert pin level
  input  wire logic       addr_match_i,          // own address matched
  input  wire logic [6:0] addr_code_i,           // received address code
  input  wire logic       addr_dir_i,            // received r/w bit
  input  wire logic       timeout_i,             // clock timeout expiry
  input  wire logic       ext_timeout_i,         // cumulative timeout
  input  wire logic       overrun_i,             // rx overrun or tx underrun
  input  wire logic       arb_lost_i,            // arbitration lost
  input  wire logic       misplaced_i,           // misplaced start/stop
  input  wire logic       slave_addr_phase_i,    // slave address phase
  input  wire logic       count_done_i,          // byte count reached
  input  wire logic       byte_count_wr_i,       // byte count written
  input  wire logic [7:0] byte_count_i,          // byte count value
  input  wire logic       start_set_i,           // software sets start
  input  wire logic       stop_set_i,            // software sets stop
  input  wire logic       own_stop_i,            // stop is self-generated
  input  wire logic       nack_rx_i,             // nack after own byte
  input  wire logic       rx_valid_i,            // byte received
  input  wire logic [7:0] rx_byte_i,             // received byte
  input  wire logic       pec_byte_i,            // received byte is pec
  input  wire logic       tx_byte_i,             // byte sent, for pec
  input  wire logic [7:0] tx_sent_i,             // sent byte value
  input  wire logic       tx_taken_i,            // tx register emptied
  input  wire logic       tx_need_i,             // tx data required
  output      logic [7:0] tx_data_o,             // transmit byte
  output      logic       busy_o,                // bus busy
  output      logic       pec_nack_o,            // nack the pec byte
  output      logic       start_clear_o,         // clear start request
  output      logic       tx_request_o           // interrupt/dma request
);

  i2csf_state_t s;
  i2csf_state_t next_s;
  logic [2:0]   pins;

  i2csf_sync #(
    .W      (3)
  ) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({scl_i, sda_i, alert_input_pin_i}),
    .init_i (3'h7),
    .q_o    (pins)
  );

  // crc-8 over one byte, msb first
  function automatic logic [7:0] pec_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    logic       fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[7] ^ d[i];
      r  = {r[6:0], 1'b0};
      if (fb) begin
        r = r ^ PEC_POLY;
      end
    end
    return r;
  endfunction

  logic wr_status;
  logic wr_clear;
  logic wr_tx;
  logic rd_rx;
  logic start_det;
  logic stop_det;
  logic alert_fall;
  logic [31:0] status_word;
  logic [31:0] clr;
  logic smb;

  assign smb       = SMBUS_SUPPORT;
  assign wr_status = wr_i && (addr_i == OFS_STATUS);
  assign wr_clear  = wr_i && (addr_i == OFS_CLEAR);
  assign wr_tx     = wr_i && (addr_i == OFS_TXDATA);
  assign rd_rx     = rd_i && (addr_i == OFS_RXDATA);
  // clear bits act on ones only
  assign clr       = wr_clear ? wdata_i : 32'h0000_0000;

  // start: sda falls with scl high; stop: sda rises with scl high
  assign start_det  = s.scl_q && pins[2] && s.sda_q && !pins[1];
  assign stop_det   = s.scl_q && pins[2] && !s.sda_q && pins[1];
  assign alert_fall = s.alert_q && !pins[0];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[BIT_ADDR_CODE +: 7] = s.matched_address_code;
    status_word[BIT_DIR]     = s.dir;
    status_word[BIT_BUSY]    = s.busy;
    status_word[BIT_ALERT]   = s.alert;
    status_word[BIT_TIMEOUT] = s.timeout;
    status_word[BIT_PEC_ERROR]   = s.packet_error_flag;
    status_word[BIT_OVERRUN]     = s.overrun_underrun_flag;
    status_word[BIT_ARB_LOST]    = s.arbitration_lost_flag;
    status_word[BIT_BUS_ERROR]   = s.bus_error_flag;
    status_word[BIT_RELOAD_DONE] = s.reload_complete_flag;
    status_word[BIT_XFER_DONE]   = s.transfer_done_flag;
    status_word[BIT_STOP]    = s.stop_seen_flag;
    status_word[BIT_NACK]    = s.nack_received_flag;
    status_word[BIT_MATCH]   = s.match;
    status_word[BIT_RX_FULL]    = s.receive_holding_full;
    status_word[BIT_TX_REQUEST] = s.transmit_request_flag;
    status_word[BIT_TX_EMPTY]   = s.transmit_holding_empty;
  end

  always_comb begin
    next_s = s;
    next_s.scl_q       = pins[2];
    next_s.sda_q       = pins[1];
    next_s.alert_q     = pins[0];
    next_s.pec_nack    = 1'b0;
    next_s.start_clear = 1'b0;

    // read data stand for exactly one cycle
    next_s.rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        OFS_STATUS: next_s.rdata = status_word;
        OFS_PEC:    next_s.rdata = {24'h00_0000, s.pec};
        OFS_RXDATA: next_s.rdata = {24'h00_0000, s.rx_data};
        default:    next_s.rdata = 32'h0000_0000;
      endcase
    end

    // software clears first, so a same-cycle hardware set wins
    if (clr[BIT_ALERT])   next_s.alert                 = 1'b0;
    if (clr[BIT_TIMEOUT]) next_s.timeout               = 1'b0;
    if (clr[BIT_PEC_ERROR]) next_s.packet_error_flag   = 1'b0;
    if (clr[BIT_OVERRUN]) next_s.overrun_underrun_flag = 1'b0;
    if (clr[BIT_ARB_LOST]) next_s.arbitration_lost_flag = 1'b0;
    if (clr[BIT_BUS_ERROR]) next_s.bus_error_flag      = 1'b0;
    if (clr[BIT_STOP])    next_s.stop_seen_flag        = 1'b0;
    if (clr[BIT_NACK])    next_s.nack_received_flag    = 1'b0;
    if (clr[BIT_MATCH]) begin
      next_s.match       = 1'b0;
      next_s.start_clear = 1'b1;
    end
    if (byte_count_wr_i && (byte_count_i != 8'h00)) begin
      next_s.reload_complete_flag = 1'b0;
    end
    if (start_set_i || stop_set_i) begin
      next_s.transfer_done_flag = 1'b0;
    end
    if (rd_rx) begin
      next_s.receive_holding_full = 1'b0;
    end

    // status writes: flush and software request
    if (wr_status && wdata_i[BIT_TX_EMPTY]) begin
      next_s.transmit_holding_empty = 1'b1;
    end
    if (wr_status && wdata_i[BIT_TX_REQUEST] &&
        clock_stretch_disable_i) begin
      next_s.transmit_request_flag = 1'b1;
    end
    // a write while the register is full is dropped
    if (wr_tx && s.transmit_holding_empty) begin
      next_s.tx_data                = wdata_i[7:0];
      next_s.transmit_holding_empty = 1'b0;
      next_s.transmit_request_flag  = 1'b0;
    end
    if (tx_taken_i) begin
      next_s.transmit_holding_empty = 1'b1;
    end
    if (tx_need_i && next_s.transmit_holding_empty) begin
      next_s.transmit_request_flag = 1'b1;
    end

    // bus conditions
    if (start_det) begin
      next_s.busy = 1'b1;
    end
    if (stop_det) begin
      next_s.busy = 1'b0;
      if ((master_mode_i && own_stop_i) ||
          (!master_mode_i && s.addressed)) begin
        next_s.stop_seen_flag = 1'b1;
      end
      next_s.addressed = 1'b0;
    end
    if (addr_match_i) begin
      next_s.matched_address_code = addr_code_i;
      next_s.dir                  = addr_dir_i;
      next_s.match                = 1'b1;
      next_s.addressed            = 1'b1;
    end

    if (smbus_host_mode_i && alert_pin_enable_i && alert_fall) begin
      next_s.alert = 1'b1;
    end
    if (timeout_i || ext_timeout_i) begin
      next_s.timeout = 1'b1;
    end
    if (overrun_i && !master_mode_i && clock_stretch_disable_i) begin
      next_s.overrun_underrun_flag = 1'b1;
    end
    if (arb_lost_i) begin
      next_s.arbitration_lost_flag = 1'b1;
    end
    if (misplaced_i && (master_mode_i || s.addressed) &&
        !(!master_mode_i && slave_addr_phase_i)) begin
      next_s.bus_error_flag = 1'b1;
    end
    if (count_done_i && reload_mode_i &&
        (master_mode_i || slave_byte_control_i)) begin
      next_s.reload_complete_flag = 1'b1;
    end
    if (count_done_i && master_mode_i && !reload_mode_i &&
        !automatic_stop_mode_i) begin
      next_s.transfer_done_flag = 1'b1;
    end
    if (nack_rx_i) begin
      next_s.nack_received_flag = 1'b1;
    end

    // receive path and packet check
    if (rx_valid_i) begin
      next_s.rx_data              = rx_byte_i;
      next_s.receive_holding_full = 1'b1;
      if (packet_check_enable_i && pec_byte_i &&
          (rx_byte_i != s.pec)) begin
        next_s.packet_error_flag = 1'b1;
        next_s.pec_nack          = 1'b1;
      end
    end
    if (packet_check_enable_i) begin
      if (rx_valid_i && !pec_byte_i) begin
        next_s.pec = pec_step(s.pec, rx_byte_i);
      end else if (tx_byte_i) begin
        next_s.pec = pec_step(s.pec, tx_sent_i);
      end
    end

    // disable forces the flags; transmit empty reads high
    if (!peripheral_enable_i) begin
      next_s.busy                   = 1'b0;
      next_s.alert                  = 1'b0;
      next_s.timeout                = 1'b0;
      next_s.packet_error_flag      = 1'b0;
      next_s.overrun_underrun_flag  = 1'b0;
      next_s.arbitration_lost_flag  = 1'b0;
      next_s.bus_error_flag         = 1'b0;
      next_s.reload_complete_flag   = 1'b0;
      next_s.transfer_done_flag     = 1'b0;
      next_s.stop_seen_flag         = 1'b0;
      next_s.nack_received_flag     = 1'b0;
      next_s.match                  = 1'b0;
      next_s.receive_holding_full   = 1'b0;
      next_s.transmit_request_flag  = 1'b0;
      next_s.transmit_holding_empty = 1'b1;
      next_s.pec                    = 8'h00;
      next_s.addressed              = 1'b0;
      next_s.pec_nack               = 1'b0;
    end

    // instances without smbus keep these at zero
    if (!smb) begin
      next_s.alert             = 1'b0;
      next_s.timeout           = 1'b0;
      next_s.packet_error_flag = 1'b0;
      next_s.pec               = 8'h00;
      next_s.pec_nack          = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.transmit_holding_empty <= STATUS_RESET[BIT_TX_EMPTY];
      s.scl_q   <= 1'b1;
      s.sda_q   <= 1'b1;
      s.alert_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o       = s.rdata;
  assign tx_data_o     = s.tx_data;
  assign busy_o        = s.busy;
  assign pec_nack_o    = s.pec_nack;
  assign start_clear_o = s.start_clear;
  // request reaches interrupt or dma logic outside
  assign tx_request_o  = s.transmit_request_flag;

endmodule

/* sim/i2csf_bus_model.sv */
// Purpose: far-side bus parties making start, stop and alert
// Assumes: pull-ups hold each line high when nobody drives it
// Notes:   scl stands still high between frames
`timescale 1ns/1ns
module i2csf_bus_model (
  output logic scl_o,   // clock line
  output logic sda_o,   // data line
  output logic alert_o  // alert line, active low
);
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
    alert_o = 1'h1;
  end
  // scl is held low inside the frame, as a real master would
  task automatic start_c;
    sda_o = 1'h0;
    #32 scl_o = 1'h0;
    #32;
  endtask
  task automatic stop_c;
    sda_o = 1'h0;
    #32 scl_o = 1'h1;
    #32 sda_o = 1'h1;
    #32;
  endtask
  // released line goes back to the pull-up level
  task automatic alert_fall;
    alert_o = 1'h0;
    #64 alert_o = 1'h1;
  endtask
endmodule

/* sim/i2csf_status_unit_checker.sv */
// Purpose: port-level checks of the status unit
// Assumes: one clock domain, async active-low reset
// Notes:   bound into every instance of the unit
`timescale 1ns/1ns
module i2csf_status_unit_checker
  import i2csf_pkg::*;
(
  input wire logic        clk_i,               // clock
  input wire logic        rstn_i,              // reset, low
  input wire logic [7:0]  addr_i,              // address
  input wire logic [31:0] wdata_i,             // write data
  input wire logic        wr_i,                // write strobe
  input wire logic        rd_i,                // read strobe
  input wire logic [31:0] rdata_o,             // read data
  input wire logic        peripheral_enable_i, // enable
  input wire logic        arb_lost_i,          // arbitration lost
  input wire logic        rx_valid_i,          // byte received
  input wire logic        pec_byte_i,          // byte is pec
  input wire logic        busy_o,              // bus busy
  input wire logic        pec_nack_o,          // pec nack
  input wire logic        start_clear_o,       // start clear
  input wire logic        tx_request_o         // transmit request
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire en = peripheral_enable_i;
  wire aclr = wr_i && addr_i == OFS_CLEAR && wdata_i[BIT_ARB_LOST];
  wire rd_st = rd_i && addr_i == OFS_STATUS;
  wire rd_rx = rd_i && addr_i == OFS_RXDATA;
  wire mclr = wr_i && addr_i == OFS_CLEAR && wdata_i[BIT_MATCH];
  clear_reads_zero_a: assert property (rd_i && addr_i == OFS_CLEAR |=>
    rdata_o == 32'h0) else $error("clear register read not zero");
  rx_upper_zero_a: assert property (rd_rx |=> rdata_o[31:8] == 24'h0)
    else $error("receive data upper bits set");
  pec_upper_zero_a: assert property (rd_i && addr_i == OFS_PEC |=>
    rdata_o[31:8] == 24'h0) else $error("pec upper bits set");
  status_res_zero_a: assert property (rd_st |=>
    rdata_o[31:24] == 8'h0 && !rdata_o[14]) else $error("status reserved set");
  off_flags_low_a: assert property (rd_st && !en && !$past(en) |=>
    rdata_o[15:0] == 16'h0001) else $error("flags not low while disabled");
  busy_off_a: assert property (!en |=> !busy_o)
    else $error("busy while disabled");
  req_off_a: assert property (!en |=> !tx_request_o)
    else $error("transmit request while disabled");
  match_clr_start_a: assert property (mclr && en |=> start_clear_o)
    else $error("start request not cleared");
  start_clr_cause_a: assert property (start_clear_o |-> $past(mclr))
    else $error("start clear without match clear");
  // the bench leaves one idle cycle between an event and the status read
  arbitration_lost_flag_seen_a: assert property (arb_lost_i && en ##1 en && !aclr
    ##1 rd_st && en |=> rdata_o[BIT_ARB_LOST])
    else $error("arbitration flag missing");
  receive_holding_full_rd_clr_a: assert property (rd_rx && !rx_valid_i && en
    ##1 !rx_valid_i && en ##1 rd_st |=> !rdata_o[BIT_RX_FULL])
    else $error("receive full not cleared");
  pec_nack_cause_a: assert property (pec_nack_o |->
    $past(rx_valid_i) && $past(pec_byte_i)) else $error("stray pec nack");
  cover property (rd_st ##1 rdata_o[BIT_ARB_LOST]);
  cover property (pec_nack_o);
  cover property ($rose(busy_o));
endmodule
bind i2csf_status_unit i2csf_status_unit_checker chk_u (
  .clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .peripheral_enable_i, .arb_lost_i, .rx_valid_i, .pec_byte_i,
  .busy_o, .pec_nack_o, .start_clear_o, .tx_request_o);

/* sim/tb_top.sv */
// Purpose: directed register-level bench of the status unit
// Assumes: bus pins come from the bus model
// Notes:   expected values follow the flag layout only
`timescale 1ns/1ns
module tb_top;
  import i2csf_pkg::*;
  logic        clk_i, rstn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
  logic [7:0]  addr_i = 8'h0, rx_b = 8'h0, bcnt = 8'h0, tx_data_o;
  logic [31:0] wdata_i = 32'h0, rdata_o, rv;
  logic [13:0] ev = '0;
  logic [10:0] cf = '0;
  logic [6:0]  code = 7'h0;
  logic        dir = 1'h0, pecb = 1'h0, scl, sda, alrt;
  logic        busy_o, pec_nack_o, start_clear_o, tx_request_o;
  int          err_total = 0, samples_checked = 0, cyc = 0;
  logic [7:0]  ofs[5] = '{OFS_STATUS, OFS_CLEAR, OFS_PEC, OFS_RXDATA, 8'h30};
  int          fbit[6] = '{9, 12, 12, 10, 8, 4};
  i2csf_status_unit dut (
    .clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .peripheral_enable_i(cf[0]), .smbus_host_mode_i(cf[1]),
    .alert_pin_enable_i(cf[2]), .clock_stretch_disable_i(cf[3]),
    .reload_mode_i(cf[4]), .automatic_stop_mode_i(cf[5]),
    .slave_byte_control_i(cf[6]), .packet_check_enable_i(cf[7]),
    .master_mode_i(cf[8]), .slave_addr_phase_i(cf[9]), .own_stop_i(cf[10]),
    .scl_i(scl), .sda_i(sda), .alert_input_pin_i(alrt),
    .arb_lost_i(ev[0]), .timeout_i(ev[1]), .ext_timeout_i(ev[2]),
    .overrun_i(ev[3]), .misplaced_i(ev[4]), .nack_rx_i(ev[5]),
    .addr_match_i(ev[6]), .addr_code_i(code), .addr_dir_i(dir),
    .count_done_i(ev[7]), .byte_count_wr_i(ev[8]), .byte_count_i(bcnt),
    .start_set_i(ev[9]), .stop_set_i(ev[10]), .rx_valid_i(ev[11]),
    .rx_byte_i(rx_b), .pec_byte_i(pecb), .tx_byte_i(1'h0),
    .tx_sent_i(8'h00), .tx_taken_i(ev[12]), .tx_need_i(ev[13]),
    .tx_data_o, .busy_o, .pec_nack_o, .start_clear_o, .tx_request_o);
  i2csf_bus_model bus (.scl_o(scl), .sda_o(sda), .alert_o(alrt));
  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    @(negedge clk_i);
    rv = rdata_o;
  endtask
  task automatic pulse(input int b);
    @(posedge clk_i);
    ev[b] <= 1'h1;
    @(posedge clk_i);
    ev <= '0;
  endtask
  task automatic flag(input int b, input logic e);
    rd(OFS_STATUS);
    chk({31'h0, rv[b]}, {31'h0, e});
  endtask
  // crc over one byte from a zero start, msb first
  function automatic logic [7:0] crc8(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      d = d[7] ? {d[6:0], 1'h0} ^ PEC_POLY : {d[6:0], 1'h0};
    return d;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'h1;
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk(rv, (i == 0) ? 32'h1 : 32'h0);
    end
    cf <= 11'h109;
    for (int i = 0; i < 6; i++) begin
      cf[8] <= (i != 3);
      pulse(i);
      flag(fbit[i], 1'h1);
      wr(OFS_CLEAR, 32'h0);
      flag(fbit[i], 1'h1);
      wr(OFS_CLEAR, 32'h1 << fbit[i]);
      flag(fbit[i], 1'h0);
    end
    pulse(3);
    flag(BIT_OVERRUN, 1'h0);
    $display("test error flags done");
    cf[8] <= 1'h0;
    code <= 7'h55;
    dir <= 1'h1;
    pulse(6);
    rd(OFS_STATUS);
    chk({24'h0, rv[23:16]}, 32'hAB);
    flag(BIT_MATCH, 1'h1);
    wr(OFS_CLEAR, 32'h8);
    @(negedge clk_i);
    chk({31'h0, start_clear_o}, 32'h1);
    flag(BIT_MATCH, 1'h0);
    bus.start_c();
    repeat (2) @(negedge clk_i);
    chk({31'h0, busy_o}, 32'h1);
    bus.stop_c();
    repeat (2) @(negedge clk_i);
    chk({31'h0, busy_o}, 32'h0);
    flag(BIT_STOP, 1'h1);
    wr(OFS_CLEAR, 32'h20);
    flag(BIT_STOP, 1'h0);
    $display("test match and stop done");
    cf[8] <= 1'h1;
    cf[4] <= 1'h1;
    pulse(7);
    flag(BIT_RELOAD_DONE, 1'h1);
    pulse(8);
    flag(BIT_RELOAD_DONE, 1'h1);
    bcnt <= 8'h05;
    pulse(8);
    flag(BIT_RELOAD_DONE, 1'h0);
    cf[4] <= 1'h0;
    for (int i = 9; i < 11; i++) begin
      pulse(7);
      flag(BIT_XFER_DONE, 1'h1);
      pulse(i);
      flag(BIT_XFER_DONE, 1'h0);
    end
    $display("test counts done");
    cf[7] <= 1'h1;
    rx_b <= 8'hA5;
    pulse(11);
    flag(BIT_RX_FULL, 1'h1);
    rd(OFS_PEC);
    chk(rv, {24'h0, crc8(8'hA5)});
    rd(OFS_RXDATA);
    chk(rv, 32'hA5);
    flag(BIT_RX_FULL, 1'h0);
    rx_b <= ~crc8(8'hA5);
    pecb <= 1'h1;
    pulse(11);
    @(negedge clk_i);
    chk({31'h0, pec_nack_o}, 32'h1);
    flag(BIT_PEC_ERROR, 1'h1);
    $display("test receive done");
    wr(OFS_TXDATA, 32'h3C);
    wr(OFS_TXDATA, 32'h77);
    @(negedge clk_i);
    chk({24'h0, tx_data_o}, 32'h3C);
    flag(BIT_TX_EMPTY, 1'h0);
    pulse(13);
    flag(BIT_TX_REQUEST, 1'h0);
    pulse(12);
    pulse(13);
    flag(BIT_TX_REQUEST, 1'h1);
    wr(OFS_TXDATA, 32'h77);
    @(negedge clk_i);
    chk({31'h0, tx_request_o}, 32'h0);
    wr(OFS_STATUS, 32'h3);
    flag(BIT_TX_EMPTY, 1'h1);
    chk({31'h0, tx_request_o}, 32'h1);
    $display("test transmit done");
    cf[2:1] <= 2'h3;
    bus.alert_fall();
    repeat (4) @(negedge clk_i);
    flag(BIT_ALERT, 1'h1);
    wr(OFS_CLEAR, 32'h2000);
    flag(BIT_ALERT, 1'h0);
    bus.alert_fall();
    bus.start_c();
    cf[0] <= 1'h0;
    rd(OFS_STATUS);
    chk({16'h0, rv[15:0]}, 32'h1);
    rd(OFS_PEC);
    chk(rv, 32'h0);
    $display("test alert and disable done");
    results();
  end
endmodule
